//--- common/pwr_defs.svh
`ifndef PWR_DEFS_SVH
`define PWR_DEFS_SVH
// register offsets on the plain register port
`define ADDR_CLOCK_DIVIDER_REG      4'h0
`define ADDR_GATE_ONE    4'h1
`define ADDR_PWR_STATUS  4'h2
// clock divider register fields
`define CLOCK_DIVIDER_REG_ROI_BIT   15
`define CLOCK_DIVIDER_REG_DOZE_HI   14
`define CLOCK_DIVIDER_REG_DOZE_LO   12
`define CLOCK_DIVIDER_REG_CPU_SLOWDOWN_ENABLE_BIT 11
`define CLOCK_DIVIDER_REG_MASK      16'hf800
// module gate register layout
`define GATE_ONE_MASK    16'h3aa9
`define GATE_T3_BIT      13
`define GATE_T2_BIT      12
`define GATE_T1_BIT      11
`define GATE_PWM_BIT     9
`define GATE_I2C_BIT     7
`define GATE_UART_BIT    5
`define GATE_SPI_BIT     3
`define GATE_ADC_BIT     0
`define GATE_ONE_RESET   16'h0000
// wake restart delay in system clock cycles (within 2 to 4)
`define WAKE_DELAY       3'h3
`define PRESENT_DEFAULT  16'h3aa9
`endif

//--- common/pwr_pkg.sv
package pwr_pkg;
    typedef enum logic [1:0] {
        RUN,
        ENTERING,
        IDLE,
        WAKING
    } pmode_t;
    typedef logic [15:0] word_t;
endpackage

//--- common/doze_if.sv
`timescale 1ns/1ps
`default_nettype none
// carries doze settings to the divider and its enable back
interface doze_if;
    logic       doze_on;
    logic [2:0] ratio;
    logic       cpu_en;
    modport ctrl (output doze_on, output ratio, input cpu_en);
    modport div  (input doze_on, input ratio, output cpu_en);
endinterface
`default_nettype wire

//--- design/doze_divider.sv
`timescale 1ns/1ps
`default_nettype none
`include "pwr_defs.svh"
module doze_divider (
    input  wire logic ref_clk,     // system clock
    input  wire logic rst_n,       // async reset, active low
    doze_if.div       dz           // doze settings and cpu enable
);
    typedef struct packed {
        logic [6:0] cnt;
        logic       en;
    } div_state_t;
    div_state_t st_reg;
    div_state_t st_next;
    logic [6:0] top;

    // ------------------------------------------------------------
    // divide by two to the power ratio
    // ------------------------------------------------------------
    always_comb begin
        top = 7'((8'h1 << dz.ratio) - 8'h1);
        st_next = st_reg;
        if (!dz.doze_on || top == 7'h0) begin
            st_next.cnt = 7'h0;
            st_next.en  = 1'b1;
        end else if (st_reg.cnt >= top) begin
            st_next.cnt = 7'h0;
            st_next.en  = 1'b1;
        end else begin
            st_next.cnt = st_reg.cnt + 7'h1;
            st_next.en  = 1'b0;
        end
    end

    // register the divider; peripherals never see this enable
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg <= '{cnt: 7'h0, en: 1'b1};
        end else begin
            st_reg <= st_next;
        end
    end
    assign dz.cpu_en = st_reg.en;

    // no two back-to-back enable pulses while dozing at ratio 1:2
    gap_len_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (dz.doze_on && dz.ratio == 3'h1 && $stable(dz.ratio) && st_reg.en)
        |=> !st_reg.en || !dz.doze_on || dz.ratio != 3'h1)
        else $error("doze 1:2 enable too frequent");
endmodule
`default_nettype wire

//--- design/power_save_clock_gating.sv
`timescale 1ns/1ps
`default_nettype none
`include "pwr_defs.svh"
// Functional notes
// - idle stops cpu enable; system clock and enabled peripherals keep running
// - entering idle pulses a watchdog clear
// - in idle keep low power rc on if watchdog or clock monitor enabled
// - enabled interrupt, reset or watchdog timeout ends idle
// - after wake the cpu enable returns a few cycles later
// - interrupt during power save instruction is held until entry completes
// - doze slows only cpu; peripherals stay on full clock
// - doze active when clock divider bit 11 set
// - bits 14:12 pick ratio 1:1 to 1:128, reset 1:1
// - bit 15 set lets interrupts restore full speed
// - module disable bit stops that peripheral clock
// - disabled peripheral ignores register writes, reads invalid
// - peripheral runs only if present and not disabled; reset enabled
// - disable change takes effect one instruction cycle after write
// - gate register bits: t3 13, t2 12, t1 11, pwm 9, i2c 7, uart 5, spi 3, adc 0
// - unimplemented gate bits read zero
// - adc disabled forces analog pins digital, config ignored
// - sleep operand stops all clocks except the rc kept by the watchdog; idle operand halts only cpu
module power_save_clock_gating #(
    parameter logic [15:0] PRESENT = `PRESENT_DEFAULT  // which peripherals exist
) (
    input  wire logic        ref_clk,          // system clock, 100 MHz
    input  wire logic        rst_n,            // async reset, active low
    input  wire logic [3:0]  reg_addr,         // register address
    input  wire logic [15:0] reg_wdata,        // register write data
    input  wire logic        reg_wr,           // write strobe
    input  wire logic        reg_rd,           // read strobe
    output logic      [15:0] reg_rdata,        // read data, cycle after strobe
    input  wire logic        power_save_instruction_exec,      // power save instruction pulse
    input  wire logic        power_save_instruction_sleep,     // operand: 1 sleep, 0 idle
    input  wire logic        irq_pending,      // enabled interrupt request
    input  wire logic        wdt_timeout,      // watchdog timeout pulse
    input  wire logic        wdt_enabled,      // watchdog enabled
    input  wire logic        clock_fail_monitor_enabled,     // clock fail monitor enabled
    input  wire logic [15:0] periph_wr,        // per peripheral sfr write request
    input  wire logic [15:0] analog_pin_config,// analog pin configuration bits
    output logic             cpu_clk_en,       // cpu advance enable
    output logic             sys_clk_en,       // system clock running
    output logic             low_power_rc_osc_en,          // low power rc oscillator on
    output logic             wdt_clear,        // watchdog clear pulse
    output logic             wake_irq,         // wake was caused by interrupt
    output logic      [15:0] periph_clk_en,    // per peripheral clock enable
    output logic      [15:0] periph_wr_ok,     // gated sfr write enables
    output logic      [15:0] periph_rd_valid,  // sfr reads valid
    output logic      [15:0] analog_pin_eff    // effective analog pin config
);
    typedef struct packed {
        pwr_pkg::pmode_t mode;
        logic            sleeping;
        logic            held_irq;
        logic [2:0]      wake_cnt;
        logic            wdt_clr;
        logic            woke_irq;
        logic [15:0]     clock_divider_reg;
        logic [15:0]     gate;
        logic [15:0]     gate_eff;
        logic            gate_pend;
        logic [15:0]     rdata;
    } ctl_state_t;

    ctl_state_t st_reg;
    ctl_state_t st_next;
    doze_if     dz ();
    logic       wake_evt;
    logic       ipl_irq;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [15:0] gate_bits(input logic [15:0] v);
        gate_bits = v & `GATE_ONE_MASK;
    endfunction

    // ------------------------------------------------------------
    // doze divider
    // ------------------------------------------------------------
    assign dz.doze_on = st_reg.clock_divider_reg[`CLOCK_DIVIDER_REG_CPU_SLOWDOWN_ENABLE_BIT];
    assign dz.ratio   = st_reg.clock_divider_reg[`CLOCK_DIVIDER_REG_DOZE_HI:`CLOCK_DIVIDER_REG_DOZE_LO];

    doze_divider u_div (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .dz      (dz)
    );

    // an interrupt seen during entry is replayed once entry completes
    assign ipl_irq  = irq_pending || st_reg.held_irq;
    assign wake_evt = ipl_irq || wdt_timeout;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        st_next = st_reg;
        st_next.wdt_clr = 1'b0;
        st_next.rdata   = 16'h0000;
        unique case (st_reg.mode)
            pwr_pkg::RUN: begin
                if (power_save_instruction_exec) begin
                    // entry takes one cycle so a coincident request is held
                    st_next.mode     = pwr_pkg::ENTERING;
                    st_next.sleeping = power_save_instruction_sleep;
                    st_next.held_irq = irq_pending;
                end
            end
            pwr_pkg::ENTERING: begin
                st_next.mode     = pwr_pkg::IDLE;
                st_next.wdt_clr  = 1'b1;
                st_next.held_irq = st_reg.held_irq || irq_pending;
            end
            pwr_pkg::IDLE: begin
                if (wake_evt) begin
                    st_next.mode     = pwr_pkg::WAKING;
                    st_next.wake_cnt = `WAKE_DELAY;
                    st_next.woke_irq = ipl_irq;
                    st_next.held_irq = 1'b0;
                end
            end
            pwr_pkg::WAKING: begin
                if (st_reg.wake_cnt == 3'h1) begin
                    st_next.mode     = pwr_pkg::RUN;
                    st_next.sleeping = 1'b0;
                    st_next.wake_cnt = 3'h0;
                end else begin
                    st_next.wake_cnt = st_reg.wake_cnt - 3'h1;
                end
            end
        endcase

        // software writes to the control registers
        if (reg_wr && reg_addr == `ADDR_CLOCK_DIVIDER_REG) begin
            st_next.clock_divider_reg = reg_wdata & `CLOCK_DIVIDER_REG_MASK;
        end
        if (reg_wr && reg_addr == `ADDR_GATE_ONE) begin
            st_next.gate      = gate_bits(reg_wdata);
            st_next.gate_pend = 1'b1;
        end
        // hardware clear wins over a same-cycle software write of cpu_slowdown_enable
        if (irq_pending && st_reg.clock_divider_reg[`CLOCK_DIVIDER_REG_ROI_BIT]
            && st_reg.clock_divider_reg[`CLOCK_DIVIDER_REG_CPU_SLOWDOWN_ENABLE_BIT]) begin
            st_next.clock_divider_reg[`CLOCK_DIVIDER_REG_CPU_SLOWDOWN_ENABLE_BIT] = 1'b0;
        end
        // effective gate lags the register by one cycle
        if (st_reg.gate_pend) begin
            st_next.gate_eff  = st_reg.gate;
            st_next.gate_pend = reg_wr && reg_addr == `ADDR_GATE_ONE;
        end

        // read data in the cycle after the strobe, unmapped reads zero
        if (reg_rd) begin
            unique case (reg_addr)
                `ADDR_CLOCK_DIVIDER_REG:     st_next.rdata = st_reg.clock_divider_reg;
                `ADDR_GATE_ONE:   st_next.rdata = gate_bits(st_reg.gate);
                `ADDR_PWR_STATUS: st_next.rdata = {12'h000, st_reg.woke_irq,
                                                   st_reg.sleeping, st_reg.mode};
                default:          st_next.rdata = 16'h0000;
            endcase
        end
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg <= '{mode: pwr_pkg::RUN, sleeping: 1'b0, held_irq: 1'b0,
                        wake_cnt: 3'h0, wdt_clr: 1'b0, woke_irq: 1'b0,
                        clock_divider_reg: 16'h0000, gate: `GATE_ONE_RESET,
                        gate_eff: `GATE_ONE_RESET, gate_pend: 1'b0,
                        rdata: 16'h0000};
        end else begin
            st_reg <= st_next;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    // cpu only advances in run mode, at the doze rate
    assign cpu_clk_en = (st_reg.mode == pwr_pkg::RUN) && dz.cpu_en;
    // sleep stops the system clock, idle keeps it
    assign sys_clk_en = !(st_reg.sleeping && st_reg.mode != pwr_pkg::RUN);
    // rc stays alive for the watchdog, and for the clock monitor outside sleep
    assign low_power_rc_osc_en    = wdt_enabled || (clock_fail_monitor_enabled && !st_reg.sleeping);
    assign wdt_clear  = st_reg.wdt_clr;
    assign wake_irq   = st_reg.woke_irq;
    assign reg_rdata  = st_reg.rdata;
    // present, not disabled and system clock running
    assign periph_clk_en   = ~st_reg.gate_eff & PRESENT & `GATE_ONE_MASK
                             & {16{sys_clk_en}};
    assign periph_wr_ok    = periph_wr & ~st_reg.gate_eff & PRESENT;
    assign periph_rd_valid = ~st_reg.gate_eff & PRESENT & `GATE_ONE_MASK;
    // adc gated: pins fall back to digital, config ignored
    assign analog_pin_eff  = (st_reg.gate_eff[`GATE_ADC_BIT] || !PRESENT[`GATE_ADC_BIT])
                             ? 16'hffff : analog_pin_config;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    idle_halts_cpu_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (st_reg.mode == pwr_pkg::IDLE) |-> !cpu_clk_en)
        else $error("cpu advanced in idle");
    entry_clears_wdt_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (st_reg.mode == pwr_pkg::RUN && power_save_instruction_exec) |=> ##1 wdt_clear)
        else $error("no watchdog clear on idle entry");
    low_power_rc_osc_kept_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (st_reg.mode == pwr_pkg::IDLE && !st_reg.sleeping && (wdt_enabled || clock_fail_monitor_enabled))
        |-> low_power_rc_osc_en)
        else $error("rc stopped in idle");
    wake_resume_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (st_reg.mode == pwr_pkg::IDLE && (irq_pending || wdt_timeout))
        |=> (st_reg.mode == pwr_pkg::WAKING)[*3] ##1 (st_reg.mode == pwr_pkg::RUN))
        else $error("wake did not resume in 3 cycles");
    held_irq_wakes_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (st_reg.mode == pwr_pkg::RUN && power_save_instruction_exec && irq_pending)
        |=> ##2 (st_reg.mode == pwr_pkg::WAKING && wake_irq))
        else $error("coincident interrupt lost");
    roi_clears_doze_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (irq_pending && st_reg.clock_divider_reg[`CLOCK_DIVIDER_REG_ROI_BIT] && st_reg.clock_divider_reg[`CLOCK_DIVIDER_REG_CPU_SLOWDOWN_ENABLE_BIT])
        |=> !st_reg.clock_divider_reg[`CLOCK_DIVIDER_REG_CPU_SLOWDOWN_ENABLE_BIT])
        else $error("doze not cleared by interrupt");
    gate_delay_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (reg_wr && reg_addr == `ADDR_GATE_ONE) |=> ##1
        (st_reg.gate_eff == $past(gate_bits(reg_wdata), 2)))
        else $error("gate change not one cycle after write");
    gate_read_zero_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (reg_rd && reg_addr == `ADDR_GATE_ONE) |=> ((reg_rdata & ~`GATE_ONE_MASK) == 16'h0000))
        else $error("reserved gate bit read nonzero");
    adc_digital_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        st_reg.gate_eff[`GATE_ADC_BIT] |-> (analog_pin_eff == 16'hffff))
        else $error("analog config used while adc gated");
    wr_blocked_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        ((periph_wr & st_reg.gate_eff) != 16'h0000) |-> ((periph_wr_ok & st_reg.gate_eff) == 16'h0000))
        else $error("write passed to gated peripheral");
endmodule
`default_nettype wire

//--- bench/cpu_periph_model.sv
`timescale 1ns/1ps
`default_nettype none
`include "pwr_defs.svh"
// -----------------------------------------------
// cpu core and timer1 stand-in
// -----------------------------------------------
module cpu_periph_model (
    input  wire logic        ref_clk,       // system clock
    input  wire logic        rst_n,         // async reset, active low
    input  wire logic        cpu_clk_en,    // cpu advance enable
    input  wire logic [15:0] periph_clk_en, // per peripheral clock enable
    output logic      [31:0] instr_count,   // instructions retired
    output logic      [31:0] t1_ticks       // timer1 clock ticks seen
);
    // the core retires one instruction per enabled cycle, timer1 counts its own clock
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            instr_count <= 32'h0;
            t1_ticks    <= 32'h0;
        end else begin
            if (cpu_clk_en)
                instr_count <= instr_count + 32'h1;
            if (periph_clk_en[`GATE_T1_BIT])
                t1_ticks <= t1_ticks + 32'h1;
        end
    end
endmodule
`default_nettype wire

//--- bench/tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "pwr_defs.svh"
module tb;
    logic        ref_clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic        power_save_instruction_exec = 1'b0, power_save_instruction_sleep = 1'b0, irq_pending = 1'b0;
    logic        wdt_timeout = 1'b0, wdt_enabled = 1'b0, clock_fail_monitor_enabled = 1'b1;
    logic [3:0]  reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0000, periph_wr = 16'hffff, analog_pin_config = 16'h1234;
    logic [15:0] reg_rdata, periph_clk_en, periph_wr_ok, periph_rd_valid, analog_pin_eff, rd, m;
    logic        cpu_clk_en, sys_clk_en, low_power_rc_osc_en, wdt_clear, wake_irq;
    logic [31:0] instr_count, t1_ticks, c0, t0;
    int          bad_count = 0, num_checks = 0, n;
    int          pos [8] = '{13, 12, 11, 9, 7, 5, 3, 0};

    always #5 ref_clk = ~ref_clk;

    power_save_clock_gating dut_u (.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .power_save_instruction_exec(power_save_instruction_exec), .power_save_instruction_sleep(power_save_instruction_sleep), .irq_pending(irq_pending),
        .wdt_timeout(wdt_timeout), .wdt_enabled(wdt_enabled), .clock_fail_monitor_enabled(clock_fail_monitor_enabled),
        .periph_wr(periph_wr), .analog_pin_config(analog_pin_config), .cpu_clk_en(cpu_clk_en),
        .sys_clk_en(sys_clk_en), .low_power_rc_osc_en(low_power_rc_osc_en), .wdt_clear(wdt_clear), .wake_irq(wake_irq),
        .periph_clk_en(periph_clk_en), .periph_wr_ok(periph_wr_ok),
        .periph_rd_valid(periph_rd_valid), .analog_pin_eff(analog_pin_eff));

    cpu_periph_model model_u (.ref_clk(ref_clk), .rst_n(rst_n), .cpu_clk_en(cpu_clk_en),
        .periph_clk_en(periph_clk_en), .instr_count(instr_count), .t1_ticks(t1_ticks));

    // -----------------------------------------------
    // checking and closing
    // -----------------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic stop_test;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // -----------------------------------------------
    // register port and timing helpers
    // -----------------------------------------------
    task automatic reg_write(input logic [3:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic reg_read(input logic [3:0] a, output logic [15:0] d);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask

    task automatic tick(input int k);
        repeat (k) @(posedge ref_clk);
        #1;
    endtask

    // bounded wait for the cpu to run again; a hang ends the run
    task automatic wait_run(output int k);
        k = 0;
        while (cpu_clk_en !== 1'b1 && k < 40) begin
            @(posedge ref_clk);
            #1;
            k++;
        end
        if (k >= 40) begin
            bad_count++;
            stop_test();
        end
    endtask

    // -----------------------------------------------
    // main sequence
    // -----------------------------------------------
    initial begin
        repeat (10) @(posedge ref_clk);
        rst_n <= 1'b1;
        // reset state of registers and enables
        reg_read(`ADDR_GATE_ONE, rd); check(rd, 16'h0000);
        reg_read(`ADDR_CLOCK_DIVIDER_REG, rd); check(rd, 16'h0000);
        reg_read(4'h3, rd); check(rd, 16'h0000);
        check(periph_clk_en, 16'h3aa9);
        check({15'h0, cpu_clk_en}, 16'h0001);
        // each gate bit alone: previous mask one cycle on, new one after
        m = 16'h0000;
        for (int i = 0; i < 8; i++) begin
            reg_write(`ADDR_GATE_ONE, 16'h0001 << pos[i]);
            #1;
            check(periph_clk_en, 16'h3aa9 & ~m);
            m = 16'h0001 << pos[i];
            tick(1);
            check(periph_clk_en, 16'h3aa9 & ~m);
            check(periph_wr_ok, 16'h3aa9 & ~m);
            check(periph_rd_valid, 16'h3aa9 & ~m);
            check(analog_pin_eff, (pos[i] == 0) ? 16'hffff : 16'h1234);
            reg_read(`ADDR_GATE_ONE, rd); check(rd, m);
        end
        reg_write(`ADDR_GATE_ONE, 16'hffff);
        reg_read(`ADDR_GATE_ONE, rd); check(rd, 16'h3aa9);
        reg_write(`ADDR_GATE_ONE, 16'h0000);
        // doze at every ratio; the peripheral clock never slows
        for (int r = 0; r < 8; r++) begin
            reg_write(`ADDR_CLOCK_DIVIDER_REG, 16'h0800 | (16'(r) << 12));
            tick(4);
            c0 = instr_count;
            t0 = t1_ticks;
            tick(256);
            check(16'(instr_count - c0), 16'h0100 >> r);
            check(16'(t1_ticks - t0), 16'h0100);
            check({15'h0, sys_clk_en}, 16'h0001);
        end
        // interrupt with and without restore on interrupt
        reg_write(`ADDR_CLOCK_DIVIDER_REG, 16'h3800);
        @(posedge ref_clk); irq_pending <= 1'b1;
        @(posedge ref_clk); irq_pending <= 1'b0;
        reg_read(`ADDR_CLOCK_DIVIDER_REG, rd); check(rd, 16'h3800);
        reg_write(`ADDR_CLOCK_DIVIDER_REG, 16'hb800);
        @(posedge ref_clk); irq_pending <= 1'b1;
        @(posedge ref_clk); irq_pending <= 1'b0;
        reg_read(`ADDR_CLOCK_DIVIDER_REG, rd); check(rd, 16'hb000);
        tick(1);
        check({15'h0, cpu_clk_en}, 16'h0001);
        reg_write(`ADDR_CLOCK_DIVIDER_REG, 16'h0000);
        // idle entry with an interrupt coinciding with the instruction
        @(posedge ref_clk); power_save_instruction_exec <= 1'b1; irq_pending <= 1'b1;
        @(posedge ref_clk); power_save_instruction_exec <= 1'b0; irq_pending <= 1'b0;
        #1;
        check({15'h0, cpu_clk_en}, 16'h0000);
        tick(1);
        check({13'h0, wdt_clear, sys_clk_en, low_power_rc_osc_en}, 16'h0007);
        wait_run(n); check(16'(n), 16'h0004);
        check({15'h0, wake_irq}, 16'h0001);
        // idle left by a watchdog timeout
        @(posedge ref_clk); power_save_instruction_exec <= 1'b1;
        @(posedge ref_clk); power_save_instruction_exec <= 1'b0;
        // the interrupt flag of the previous wake stays until the next wake
        reg_read(`ADDR_PWR_STATUS, rd); check(rd, 16'h000a);
        tick(3);
        check({14'h0, cpu_clk_en, sys_clk_en}, 16'h0001);
        @(posedge ref_clk); wdt_timeout <= 1'b1;
        @(posedge ref_clk); wdt_timeout <= 1'b0;
        #1;
        wait_run(n); check(16'(n), 16'h0003);
        check({15'h0, wake_irq}, 16'h0000);
        // sleep stops everything but the rc kept by the watchdog; only a reset ends it here
        @(posedge ref_clk); power_save_instruction_exec <= 1'b1; power_save_instruction_sleep <= 1'b1;
        @(posedge ref_clk); power_save_instruction_exec <= 1'b0; power_save_instruction_sleep <= 1'b0;
        tick(4);
        check({13'h0, cpu_clk_en, sys_clk_en, low_power_rc_osc_en}, 16'h0000);
        check(periph_clk_en, 16'h0000);
        @(posedge ref_clk); wdt_enabled <= 1'b1;
        tick(1);
        check({15'h0, low_power_rc_osc_en}, 16'h0001);
        @(posedge ref_clk); rst_n <= 1'b0;
        @(posedge ref_clk); rst_n <= 1'b1;
        tick(1);
        check({14'h0, cpu_clk_en, sys_clk_en}, 16'h0003);
        stop_test();
    end
endmodule
`default_nettype wire
